// ==== core/exec_pkg.sv ====
package exec_pkg;
	// Bus widths
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	localparam int FADDR_W = 12;
	localparam int BANK_W = 4;
	// Instruction encodings: match value and mask over the 16-bit word
	localparam logic [15:0] ENC_SUB = 16'h5800;
	localparam logic [15:0] MSK_SUB = 16'hFC00;
	localparam logic [15:0] ENC_SWAP = 16'h3800;
	localparam logic [15:0] MSK_SWAP = 16'hFC00;
	localparam logic [15:0] ENC_MULL = 16'h0D00;
	localparam logic [15:0] MSK_MULL = 16'hFF00;
	localparam logic [15:0] ENC_MULF = 16'h0200;
	localparam logic [15:0] MSK_MULF = 16'hFE00;
	localparam logic [15:0] ENC_TBL = 16'h0008;
	localparam logic [15:0] MSK_TBL = 16'hFFFC;
	// Operand field positions
	localparam int POS_DEST = 9;
	localparam int POS_BANK = 8;
	localparam int POS_MULF_BANK = 8;
	// Access bank split: low addresses map to bank 0, the rest to the top bank
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] BANK_LOW = 4'h0;
	localparam logic [3:0] BANK_HIGH = 4'hF;
	// Status bit positions
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_OV = 3;
	localparam int ST_N = 4;
	localparam int ST_W = 5;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [4:0] RST_STATUS = 5'h00;
	// Table pointer update modes
	typedef enum logic [1:0] {
		TM_KEEP = 2'h0,
		TM_POSTINC = 2'h1,
		TM_POSTDEC = 2'h2,
		TM_PREINC = 2'h3
	} tbl_mode_t;
	// Instruction phases, Gray coded
	typedef enum logic [1:0] {
		PH_Q1 = 2'h0,
		PH_Q2 = 2'h1,
		PH_Q3 = 2'h3,
		PH_Q4 = 2'h2
	} phase_t;
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_SUB = 3'h1,
		OP_SWAP = 3'h2,
		OP_MULL = 3'h3,
		OP_MULF = 3'h4,
		OP_TBL = 3'h5
	} op_t;
endpackage

// ==== core/exec_alu_if.sv ====
`timescale 1ns/1ns
interface exec_alu_if;
	import exec_pkg::*;
	op_t op;
	logic [DATA_W-1:0] opnd;
	logic [DATA_W-1:0] w;
	logic cin;
	logic [DATA_W-1:0] res;
	logic [ST_W-1:0] flags;
	logic [WORD_W-1:0] prod;
	modport ctrl (output op, output opnd, output w, output cin,
		input res, input flags, input prod);
	modport alu (input op, input opnd, input w, input cin,
		output res, output flags, output prod);
endinterface

// ==== core/exec_alu.sv ====
`timescale 1ns/1ns
module exec_alu
	import exec_pkg::*;
(
	exec_alu_if.alu bus
);
	logic [DATA_W:0] sum;
	logic [4:0] low_sum;
	always_comb begin
		sum = {1'b0, bus.opnd} + {1'b0, ~bus.w} + {{DATA_W{1'b0}}, bus.cin};
		low_sum = {1'b0, bus.opnd[3:0]} + {1'b0, ~bus.w[3:0]} + {4'h0, bus.cin};
		bus.prod = {{DATA_W{1'b0}}, bus.opnd} * {{DATA_W{1'b0}}, bus.w};
		bus.flags = '0;
		bus.res = sum[DATA_W-1:0];
		unique case (bus.op)
			OP_SUB: begin
				bus.flags[ST_C] = sum[DATA_W];
				bus.flags[ST_DC] = low_sum[4];
				bus.flags[ST_Z] = (sum[DATA_W-1:0] == RST_BYTE);
				bus.flags[ST_N] = sum[DATA_W-1];
				bus.flags[ST_OV] = (bus.opnd[7] != bus.w[7]) && (sum[7] != bus.opnd[7]);
			end
			OP_SWAP: bus.res = {bus.opnd[3:0], bus.opnd[7:4]};
			default: bus.res = bus.opnd;
		endcase
	end
endmodule

// ==== core/exec_datapath.sv ====
`timescale 1ns/1ns
// Overview of operation
// - Subtract-with-borrow computes file minus accumulator minus inverted carry and sets N, OV, C, DC, Z.
// - Destination bit 0 writes the accumulator, 1 writes back to the file register.
// - Bank bit 0 uses the access bank, 1 uses the bank select register.
// - Nibble exchange swaps the file register nibbles into the destination and keeps all flags.
// - The table pointer is a 21-bit byte address into program memory.
// - Pointer bit 0 picks the low byte when 0 and the high byte when 1.
// - The table read mode field keeps, post-increments, post-decrements or pre-increments the pointer.
// - A table read takes two instruction cycles, reading memory in the second and loading the latch in its last phase.
// - Multiply forms the unsigned 16-bit product of the accumulator and a literal or file register into the product pair.
// - Multiply leaves status, accumulator and source register unchanged.
module exec_datapath
	import exec_pkg::*;
#(
	parameter int PTR_W = 21
)(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [WORD_W-1:0] instr,
	input wire logic instr_valid,
	input wire logic [BANK_W-1:0] bank_select_reg,
	input wire logic [DATA_W-1:0] file_rdata,
	input wire logic [WORD_W-1:0] prog_rdata,
	output logic instr_taken,
	output logic [FADDR_W-1:0] file_addr,
	output logic file_we,
	output logic [DATA_W-1:0] file_wdata,
	output logic [PTR_W-2:0] prog_addr,
	output logic [DATA_W-1:0] acc,
	output logic [ST_W-1:0] status,
	output logic [DATA_W-1:0] product_high_byte,
	output logic [DATA_W-1:0] product_low_byte,
	output logic [PTR_W-1:0] program_byte_pointer,
	output logic [DATA_W-1:0] program_fetch_latch
);
	if (PTR_W < 2) begin : g_bad_ptr
		$error("PTR_W must be at least 2");
	end
	localparam logic [PTR_W-1:0] PTR_STEP = {{(PTR_W-1){1'b0}}, 1'b1};

	function automatic op_t decode(input logic [WORD_W-1:0] w);
		if ((w & MSK_SUB) == ENC_SUB) return OP_SUB;
		if ((w & MSK_SWAP) == ENC_SWAP) return OP_SWAP;
		if ((w & MSK_MULL) == ENC_MULL) return OP_MULL;
		if ((w & MSK_MULF) == ENC_MULF) return OP_MULF;
		if ((w & MSK_TBL) == ENC_TBL) return OP_TBL;
		return OP_NONE;
	endfunction

	exec_alu_if alu_bus ();
	exec_alu u_alu (.bus(alu_bus));

	phase_t phase;
	op_t op;
	logic [WORD_W-1:0] ir;
	logic second;
	logic [DATA_W-1:0] operand;
	logic [WORD_W-1:0] fetch_word;
	tbl_mode_t mode;
	logic ir_dest;
	logic ir_bank;

	assign mode = tbl_mode_t'(ir[1:0]);
	assign ir_dest = ir[POS_DEST];
	assign ir_bank = (op == OP_MULF) ? ir[POS_MULF_BANK] : ir[POS_BANK];
	assign alu_bus.op = op;
	assign alu_bus.opnd = (op == OP_MULL) ? ir[DATA_W-1:0] : operand;
	assign alu_bus.w = acc;
	assign alu_bus.cin = status[ST_C];

	// Phase sequencer, one phase per clock
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			phase <= PH_Q1;
		end else begin
			unique case (phase)
				PH_Q1: phase <= PH_Q2;
				PH_Q2: phase <= PH_Q3;
				PH_Q3: phase <= PH_Q4;
				PH_Q4: phase <= PH_Q1;
			endcase
		end
	end

	// Instruction capture and file address
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ir <= '0;
			op <= OP_NONE;
			instr_taken <= 1'b0;
			file_addr <= '0;
		end else begin
			instr_taken <= 1'b0;
			if (phase == PH_Q1 && !second) begin
				instr_taken <= instr_valid;
				ir <= instr;
				op <= instr_valid ? decode(instr) : OP_NONE;
				if (instr[POS_BANK]) begin
					file_addr <= {bank_select_reg, instr[7:0]};
				end else if (instr[7:0] < ACCESS_SPLIT) begin
					file_addr <= {BANK_LOW, instr[7:0]};
				end else begin
					file_addr <= {BANK_HIGH, instr[7:0]};
				end
			end
		end
	end

	// Operand read in phase two
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			operand <= RST_BYTE;
		end else if (phase == PH_Q2 && !second) begin
			operand <= file_rdata;
		end
	end

	// Destination write in phase four
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			acc <= RST_BYTE;
			file_we <= 1'b0;
			file_wdata <= RST_BYTE;
			status <= RST_STATUS;
			product_high_byte <= RST_BYTE;
			product_low_byte <= RST_BYTE;
		end else begin
			file_we <= 1'b0;
			if (phase == PH_Q4 && !second) begin
				if (op == OP_SUB || op == OP_SWAP) begin
					if (ir_dest) begin
						file_we <= 1'b1;
						file_wdata <= alu_bus.res;
					end else begin
						acc <= alu_bus.res;
					end
				end
				if (op == OP_SUB) begin
					status <= alu_bus.flags;
				end
				if (op == OP_MULL || op == OP_MULF) begin
					product_high_byte <= alu_bus.prod[WORD_W-1:DATA_W];
					product_low_byte <= alu_bus.prod[DATA_W-1:0];
				end
			end
		end
	end

	// Two-cycle table read
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			second <= 1'b0;
			program_byte_pointer <= '0;
			prog_addr <= '0;
			fetch_word <= '0;
			program_fetch_latch <= RST_BYTE;
		end else if (op == OP_TBL) begin
			if (phase == PH_Q4 && !second) begin
				second <= 1'b1;
				if (mode == TM_PREINC) begin
					program_byte_pointer <= program_byte_pointer + PTR_STEP;
				end
			end else if (second) begin
				unique case (phase)
					PH_Q1: prog_addr <= program_byte_pointer[PTR_W-1:1];
					PH_Q2: fetch_word <= prog_rdata;
					PH_Q3: ;
					PH_Q4: begin
						second <= 1'b0;
						program_fetch_latch <= program_byte_pointer[0] ?
							fetch_word[WORD_W-1:DATA_W] : fetch_word[DATA_W-1:0];
						if (mode == TM_POSTINC) begin
							program_byte_pointer <= program_byte_pointer + PTR_STEP;
						end else if (mode == TM_POSTDEC) begin
							program_byte_pointer <= program_byte_pointer - PTR_STEP;
						end
					end
				endcase
			end
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	logic end_one;
	assign end_one = phase == PH_Q4 && !second;

	chk_sub_result: assert property (end_one && op == OP_SUB && !ir_dest |=>
		acc == $past(operand) - $past(acc) - {7'h00, !$past(status[ST_C])})
		else $error("subtract result wrong");
	chk_dest_acc: assert property (end_one && (op == OP_SUB || op == OP_SWAP)
		|=> file_we == $past(ir_dest))
		else $error("destination select wrong");
	chk_bank_access: assert property (phase == PH_Q2 && !ir_bank |->
		file_addr[11:8] == ((file_addr[7:0] < ACCESS_SPLIT) ? BANK_LOW : BANK_HIGH))
		else $error("access bank mapping wrong");
	chk_swap_nibbles: assert property (end_one && op == OP_SWAP && ir_dest |=>
		file_wdata == {$past(operand[3:0]), $past(operand[7:4])})
		else $error("swap result wrong");
	chk_swap_flags: assert property (end_one && op != OP_SUB |=> $stable(status))
		else $error("flags changed");
	chk_tbl_two_cyc: assert property (end_one && op == OP_TBL |=> second [*4] ##1 !second)
		else $error("table read length wrong");
	chk_tbl_byte: assert property (second && phase == PH_Q4 |=>
		program_fetch_latch == ($past(program_byte_pointer[0]) ?
		$past(fetch_word[15:8]) : $past(fetch_word[7:0])))
		else $error("table byte select wrong");
	chk_ptr_postinc: assert property (second && phase == PH_Q4 && mode == TM_POSTINC
		|=> program_byte_pointer == $past(program_byte_pointer) + PTR_STEP)
		else $error("post-increment wrong");
	chk_mul_product: assert property (end_one && op == OP_MULL |=>
		{product_high_byte, product_low_byte} == $past(acc) * $past(ir[7:0]))
		else $error("product wrong");
	chk_mul_keep: assert property (end_one && (op == OP_MULF || op == OP_MULL)
		|=> $stable(acc) && !file_we)
		else $error("multiply disturbed state");
	chk_write_phase: assert property (file_we |-> phase == PH_Q1)
		else $error("write outside phase four");

	cov_sub: cover property (end_one && op == OP_SUB && status[ST_C]);
	cov_tbl_pre: cover property (second && phase == PH_Q4 && mode == TM_PREINC);
	cov_mulf: cover property (end_one && op == OP_MULF);
endmodule

// ==== testbench/tb_alu_mul_sub_swap_table_read.sv ====
`timescale 1ns/1ns
module tb_alu_mul_sub_swap_table_read;
	import exec_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic instr_valid = 1'b0;
	logic [3:0] bank_select_reg = 4'h0;
	logic [7:0] file_rdata = 8'h00;
	logic [15:0] prog_rdata = 16'h0000;
	logic instr_taken;
	logic file_we;
	logic [11:0] file_addr;
	logic [7:0] file_wdata;
	logic [19:0] prog_addr;
	logic [7:0] acc;
	logic [4:0] status;
	logic [7:0] product_high_byte;
	logic [7:0] product_low_byte;
	logic [20:0] program_byte_pointer;
	logic [7:0] program_fetch_latch;
	int errors = 0;
	int samples_checked = 0;
	logic [31:0] seed = 32'hE4BAF99D;
	logic [24:0] notes[$];
	event ev;
	logic [7:0] m_acc = 8'h00;
	logic [4:0] m_st = 5'h00;
	logic [15:0] m_prod = 16'h0000;
	logic [20:0] m_ptr = 21'h000000;
	logic [7:0] m_lat = 8'h00;
	logic [7:0] x_wd = 8'h00;
	logic [7:0] x_lat = 8'h00;
	logic [11:0] x_addr = 12'h000;
	logic [19:0] x_pa = 20'h00000;
	logic x_we = 1'b0;
	logic x_ca = 1'b0;
	always #5 core_clk = ~core_clk;
	exec_datapath #(.PTR_W(21)) dut (.core_clk(core_clk), .resetn(resetn), .instr(instr),
		.instr_valid(instr_valid), .bank_select_reg(bank_select_reg),
		.file_rdata(file_rdata), .prog_rdata(prog_rdata), .instr_taken(instr_taken),
		.file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
		.prog_addr(prog_addr), .acc(acc), .status(status),
		.product_high_byte(product_high_byte), .product_low_byte(product_low_byte),
		.program_byte_pointer(program_byte_pointer),
		.program_fetch_latch(program_fetch_latch));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [20:0] seen(input logic [3:0] k);
		case (k)
			4'h0: seen = {20'h00000, instr_taken};
			4'h1: seen = {9'h000, file_addr};
			4'h2: seen = {20'h00000, file_we};
			4'h3: seen = {13'h0000, file_wdata};
			4'h4: seen = {13'h0000, acc};
			4'h5: seen = {16'h0000, status};
			4'h6: seen = {5'h00, product_high_byte, product_low_byte};
			4'h7: seen = program_byte_pointer;
			4'h8: seen = {13'h0000, program_fetch_latch};
			default: seen = {1'b0, prog_addr};
		endcase
	endfunction
	task automatic note(input logic [3:0] k, input logic [20:0] v);
		notes.push_back({k, v});
	endtask
	task automatic check(input logic [20:0] got, input logic [20:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic expect_all();
		note(4'h2, {20'h00000, x_we});
		if (x_we) note(4'h3, {13'h0000, x_wd});
		note(4'h4, {13'h0000, m_acc});
		note(4'h5, {16'h0000, m_st});
		note(4'h6, {5'h00, m_prod});
		note(4'h7, m_ptr);
		note(4'h8, {13'h0000, m_lat});
		->ev;
	endtask
	// Drive at a falling edge just before a Q1 edge; runs k+1 instruction cycles for a k-cycle instruction
	task automatic run_op(input logic [15:0] code, input int k);
		logic [31:0] v;
		instr <= code;
		instr_valid <= 1'b1;
		for (int i = 0; i < 4 * k + 4; i++) begin
			@(negedge core_clk);
			v = rnd();
			if (i == 0 || i == 4) begin
				instr <= v[15:0];
				instr_valid <= 1'b0;
			end
			if (i == 3 && k == 2) begin
				instr <= 16'h3B55;
				instr_valid <= 1'b1;
			end
			if (i < 2) begin
				note(4'h0, {20'h00000, (i == 0) ? 1'b1 : 1'b0});
				if (x_ca) note(4'h1, {9'h000, x_addr});
				->ev;
			end
			if (i == 4 && k == 2) begin
				note(4'h0, 21'h000000);
				note(4'h8, {13'h0000, m_lat});
				->ev;
			end
			if (i == 4 * k - 1) begin
				if (k == 2) begin
					m_lat = x_lat;
					note(4'h9, {1'b0, x_pa});
				end
				expect_all();
			end
		end
	endtask
	initial begin
		logic [24:0] n;
		forever begin
			@(ev);
			while (notes.size() > 0) begin
				n = notes.pop_front();
				check(seen(n[24:21]), n[20:0]);
			end
		end
	end
	initial begin
		#300000;
		errors++;
		end_sim();
	end
	initial begin
		logic [31:0] v;
		logic [7:0] f;
		logic [7:0] fa;
		logic [7:0] r;
		logic [8:0] t;
		logic [4:0] t4;
		logic [20:0] ad;
		logic [1:0] modes[8];
		modes = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1, 2'h2};
		repeat (12) @(negedge core_clk);
		expect_all();
		resetn <= 1'b1;
		for (int j = 0; j < 60; j++) begin
			v = rnd();
			f = v[7:0];
			fa = v[31:24];
			file_rdata <= f;
			bank_select_reg <= v[15:12];
			x_addr = {v[9] ? v[15:12] : (fa < ACCESS_SPLIT ? BANK_LOW : BANK_HIGH), fa};
			x_ca = (v[11:10] != 2'h2);
			x_we = 1'b0;
			case (v[11:10])
				2'h0: begin
					t = {1'b0, f} - {1'b0, m_acc} - {8'h00, ~m_st[0]};
					t4 = {1'b0, f[3:0]} - {1'b0, m_acc[3:0]} - {4'h0, ~m_st[0]};
					r = t[7:0];
					m_st = {r[7], (f[7] != m_acc[7]) && (r[7] != f[7]), r == 8'h00, ~t4[4], ~t[8]};
				end
				2'h1: r = {f[3:0], f[7:4]};
				2'h2: m_prod = m_acc * v[23:16];
				default: m_prod = m_acc * f;
			endcase
			if (v[11] == 1'b0) begin
				x_we = v[8];
				x_wd = r;
				if (!v[8]) m_acc = r;
			end
			case (v[11:10])
				2'h0: run_op(ENC_SUB | {6'h00, v[8], v[9], fa}, 1);
				2'h1: run_op(ENC_SWAP | {6'h00, v[8], v[9], fa}, 1);
				2'h2: run_op(ENC_MULL | {8'h00, v[23:16]}, 1);
				default: run_op(ENC_MULF | {7'h00, v[9], fa}, 1);
			endcase
		end
		x_we = 1'b0;
		x_ca = 1'b0;
		for (int j = 0; j < 8; j++) begin
			v = rnd();
			prog_rdata <= v[15:0];
			ad = (modes[j] == 2'h3) ? m_ptr + 21'h000001 : m_ptr;
			m_ptr = (modes[j] == 2'h1) ? ad + 21'h000001 : (modes[j] == 2'h2) ? ad - 21'h000001 : ad;
			x_lat = ad[0] ? v[15:8] : v[7:0];
			x_pa = ad[20:1];
			run_op(ENC_TBL | {14'h0000, modes[j]}, 2);
		end
		end_sim();
	end
endmodule
